// file: common/dsc_defines.svh
// Purpose: Constants of the line-status and chain-control register bank
// Assumes: AXI4-Lite with 32-bit data, byte address = index times four
// Notes:   Included by the package and the design
//
// Overview of operation
// [R1] Link error sticks until software writes zero
// [R2] Frame lock flag mirrors link lock, read-only
// [R3] Loop current level in 6 mA steps
// [R4] International support identifier is read-only
// [R5] Line-side revision code is read-only
// [R6] Receive boost bit adds 6 dB gain
// [R7] Transmit cut bit adds 3 dB attenuation
// [R8] Software clears legacy bits using extended gains
// [R9] Follower count selects zero to seven followers
// [R10] Four or more followers need short spacing
// [R11] Receive word format selects 16/15-bit words
// [R12] Frame syncs every 32 or 16 serial clocks
// [R13] Followers need short spacing; master mode 1
// [R14] Ring polarity bit sets ring output level
// [R15] Chain enable repurposes ring and sync pins
// [R16] Chain enable low ignores other chain bits
// [R17] Chain reset value depends on serial mode
// [R18] Read-only writes ignored, reserved bits read zero
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// ************************************************
// Register map
// ************************************************
`define DSC_IDX_LINE_STATUS  8'h0c
`define DSC_IDX_REV_GAIN     8'h0d
`define DSC_IDX_CHAIN_CTL    8'h0e
`define DSC_ADDR_LINE_STATUS 8'(`DSC_IDX_LINE_STATUS * 8'h04)
`define DSC_ADDR_REV_GAIN    8'(`DSC_IDX_REV_GAIN * 8'h04)
`define DSC_ADDR_CHAIN_CTL   8'(`DSC_IDX_CHAIN_CTL * 8'h04)
`define DSC_ADDR_INT_STATUS  8'h40
`define DSC_ADDR_INT_CLEAR   8'h44
`define DSC_ADDR_INT_ENABLE  8'h48

// ************************************************
// Fields
// ************************************************
`define DSC_BIT_LINK_ERR     7
`define DSC_BIT_RX_BOOST     1
`define DSC_BIT_TX_CUT       0
`define DSC_INT_LINK_ERR     0
`define DSC_INT_LOCK_LOST    1
`define DSC_INT_RING         2

// ************************************************
// Reset values and timing
// ************************************************
`define DSC_CHAIN_RST_M01    8'h02
`define DSC_CHAIN_RST_M2     8'h3f
`define DSC_SERIAL_MODE2     2'h2
`define DSC_FRAME_LONG       6'h20
`define DSC_FRAME_SHORT      6'h10
`define DSC_RESP_OKAY        2'h0
`define DSC_RESP_SLVERR      2'h2

`endif

// file: common/dsc_pkg.sv
// Purpose: Types shared by the register bank
// Assumes: Constants come from dsc_defines.svh
// Notes:   Line inputs travel as one bundle through the synchroniser
`include "dsc_defines.svh"
package dsc_pkg;

    typedef struct packed {
        logic       fault;
        logic       lock;
        logic [3:0] loopLevel;
        logic       intlSupport;
        logic [3:0] revision;
        logic       ring;
    } dsc_line_in_type;

    typedef struct packed {
        logic       enable;
        logic [2:0] followerCount;
        logic [1:0] rxWordFormat;
        logic       shortSpacing;
        logic       ringPolarity;
    } dsc_chain_cfg_type;

    typedef struct packed {
        dsc_line_in_type lineS1;
        dsc_line_in_type lineS2;
        logic [1:0]      modeS1;
        logic [1:0]      modeS2;
        logic [1:0]      startCnt;
        logic            sclkS1;
        logic            sclkS2;
        logic            sclkS3;
        logic            linkErr;
        logic            rxBoost;
        logic            txCut;
        logic [7:0]      chainCtl;
        logic [2:0]      intStat;
        logic [2:0]      intEn;
        logic            lockPrev;
        logic            ringPrev;
        logic [5:0]      frameCnt;
        logic            framePulse;
        logic            ringPin;
        logic            awHeld;
        logic            wHeld;
        logic [7:0]      awAddr;
        logic [7:0]      wData;
        logic            wLane0;
        logic            bValid;
        logic [1:0]      bResp;
        logic            rValid;
        logic [7:0]      rData;
        logic [1:0]      rResp;
    } dsc_state_type;

endpackage

// file: design/dsc_reg_bank.sv
// Purpose: Line status, line-side revision/gain and chain control registers
// Assumes: AXI4-Lite slave on clk_sys; line pins are asynchronous
// Notes:   Serial clock is sampled, not used as a clock
`timescale 1ns/1ns
`include "dsc_defines.svh"
module dsc_reg_bank
    import dsc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_sys,         // System clock, 250 MHz
    input  wire logic              rst_b,           // Async reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,    // Write address
    input  wire logic              s_axi_awvalid,   // Write address valid
    output logic                   s_axi_awready,   // Write address ready
    input  wire logic [31:0]       s_axi_wdata,     // Write data
    input  wire logic [3:0]        s_axi_wstrb,     // Write byte strobes
    input  wire logic              s_axi_wvalid,    // Write data valid
    output logic                   s_axi_wready,    // Write data ready
    output logic [1:0]             s_axi_bresp,     // Write response
    output logic                   s_axi_bvalid,    // Write response valid
    input  wire logic              s_axi_bready,    // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,    // Read address
    input  wire logic              s_axi_arvalid,   // Read address valid
    output logic                   s_axi_arready,   // Read address ready
    output logic [31:0]            s_axi_rdata,     // Read data
    output logic [1:0]             s_axi_rresp,     // Read response
    output logic                   s_axi_rvalid,    // Read data valid
    input  wire logic              s_axi_rready,    // Read data ready
    input  wire dsc_line_in_type   lineIn,          // Line-side status pins
    input  wire logic              serialClkPin,    // Serial bus clock
    input  wire logic [1:0]        serialModePin,   // Serial mode strap
    input  wire logic              controlIn,       // Control level, unchained
    output logic                   ringOrControlPin, // Ring detect or control
    output logic                   delayedSyncPin,  // Delayed frame sync
    output logic                   rxBoost,         // Receive 6 dB boost
    output logic                   txCut,           // Transmit 3 dB cut
    output dsc_chain_cfg_type      chainCfg,        // Effective chain setup
    output logic                   irq              // Interrupt, active high
);

    // ************************************************
    // Reset release
    // ************************************************
    logic [1:0] rstSync;
    logic       rstSyncB;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstSyncB = rstSync[1];

    // ************************************************
    // State
    // ************************************************
    dsc_state_type s;
    dsc_state_type n;

    logic       sclkRise;
    logic       wrFire;
    logic       rdFire;
    logic [7:0] rdAddr;
    logic [7:0] rdVal;
    logic [1:0] rdResp;
    logic [1:0] wrResp;
    logic [2:0] intEvents;
    logic [2:0] intClear;
    logic [5:0] framePeriod;
    logic       chainOn;

    assign s_axi_awready = !s.awHeld;
    assign s_axi_wready  = !s.wHeld;
    assign s_axi_arready = !s.rValid;
    assign s_axi_bvalid  = s.bValid;
    assign s_axi_bresp   = s.bResp;
    assign s_axi_rvalid  = s.rValid;
    assign s_axi_rresp   = s.rResp;
    assign s_axi_rdata   = {24'h00_0000, s.rData};

    assign rdAddr   = 8'(s_axi_araddr);
    assign wrFire   = s.awHeld && s.wHeld && !s.bValid;
    assign rdFire   = s_axi_arvalid && !s.rValid;
    assign sclkRise = s.sclkS2 && !s.sclkS3;
    assign chainOn  = s.chainCtl[0];

    // Gates every other chain bit behind the enable
    always_comb begin
        chainCfg = '0;
        if (chainOn) begin                                  // [R16]
            chainCfg.enable        = 1'b1;                  // [R15]
            chainCfg.followerCount = s.chainCtl[7:5];       // [R9]
            chainCfg.rxWordFormat  = s.chainCtl[4:3];       // [R11]
            chainCfg.shortSpacing  = s.chainCtl[2];
            chainCfg.ringPolarity  = s.chainCtl[1];
        end
    end

    assign rxBoost          = s.rxBoost;                    // [R6]
    assign txCut            = s.txCut;                      // [R7]
    assign ringOrControlPin = s.ringPin;
    assign delayedSyncPin   = s.framePulse;
    assign irq              = |(s.intStat & s.intEn);

    // ************************************************
    // Read decode
    // ************************************************
    always_comb begin
        rdVal  = 8'h00;
        rdResp = `DSC_RESP_OKAY;
        if (rdAddr == `DSC_ADDR_LINE_STATUS) begin
            rdVal = {s.linkErr, s.lineS2.lock, 2'h0,        // [R2] [R18]
                     s.lineS2.loopLevel};                   // [R3]
        end else if (rdAddr == `DSC_ADDR_REV_GAIN) begin
            rdVal = {1'b0, s.lineS2.intlSupport,            // [R4]
                     s.lineS2.revision,                     // [R5]
                     s.rxBoost, s.txCut};
        end else if (rdAddr == `DSC_ADDR_CHAIN_CTL) begin
            // Word format field is write-only
            rdVal = {s.chainCtl[7:5], 2'h0, s.chainCtl[2:0]};
        end else if (rdAddr == `DSC_ADDR_INT_STATUS) begin
            rdVal = {5'h00, s.intStat};
        end else if (rdAddr == `DSC_ADDR_INT_CLEAR) begin
            rdVal = 8'h00;
        end else if (rdAddr == `DSC_ADDR_INT_ENABLE) begin
            rdVal = {5'h00, s.intEn};
        end else begin
            rdResp = `DSC_RESP_SLVERR;
        end
    end

    // ************************************************
    // Write decode response
    // ************************************************
    always_comb begin
        wrResp = `DSC_RESP_SLVERR;
        if (s.awAddr == `DSC_ADDR_LINE_STATUS) begin
            wrResp = `DSC_RESP_OKAY;
        end else if (s.awAddr == `DSC_ADDR_REV_GAIN) begin
            wrResp = `DSC_RESP_OKAY;
        end else if (s.awAddr == `DSC_ADDR_CHAIN_CTL) begin
            wrResp = `DSC_RESP_OKAY;
        end else if (s.awAddr == `DSC_ADDR_INT_STATUS) begin
            wrResp = `DSC_RESP_OKAY;
        end else if (s.awAddr == `DSC_ADDR_INT_CLEAR) begin
            wrResp = `DSC_RESP_OKAY;
        end else if (s.awAddr == `DSC_ADDR_INT_ENABLE) begin
            wrResp = `DSC_RESP_OKAY;
        end
    end

    // ************************************************
    // Interrupt sources
    // ************************************************
    always_comb begin
        intEvents = 3'h0;
        intEvents[`DSC_INT_LINK_ERR]  = s.lineS2.fault && !s.linkErr;
        intEvents[`DSC_INT_LOCK_LOST] = s.lockPrev && !s.lineS2.lock;
        intEvents[`DSC_INT_RING]      = s.lineS2.ring && !s.ringPrev;
        intClear = 3'h0;
        if (wrFire && s.wLane0 && s.awAddr == `DSC_ADDR_INT_CLEAR) begin
            intClear = s.wData[2:0];
        end
    end

    assign framePeriod = chainCfg.shortSpacing ? `DSC_FRAME_SHORT
                                               : `DSC_FRAME_LONG;

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        n = s;

        // Synchronisers; first stage feeds only the second
        n.lineS1 = lineIn;
        n.lineS2 = s.lineS1;
        n.modeS1 = serialModePin;
        n.modeS2 = s.modeS1;
        n.sclkS1 = serialClkPin;
        n.sclkS2 = s.sclkS1;
        n.sclkS3 = s.sclkS2;
        n.lockPrev = s.lineS2.lock;
        n.ringPrev = s.lineS2.ring;

        // Strap settles through the synchroniser before capture
        if (s.startCnt != 2'h3) begin
            n.startCnt = s.startCnt + 2'h1;
            if (s.startCnt == 2'h2) begin
                if (s.modeS2 == `DSC_SERIAL_MODE2) begin
                    n.chainCtl = `DSC_CHAIN_RST_M2;         // [R17]
                end else begin
                    n.chainCtl = `DSC_CHAIN_RST_M01;        // [R17]
                end
            end
        end

        // Write address and data taken in either order
        if (s_axi_awvalid && !s.awHeld) begin
            n.awHeld = 1'b1;
            n.awAddr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && !s.wHeld) begin
            n.wHeld  = 1'b1;
            n.wData  = s_axi_wdata[7:0];
            n.wLane0 = s_axi_wstrb[0];
        end
        if (s.bValid && s_axi_bready) begin
            n.bValid = 1'b0;
        end

        if (wrFire) begin
            n.awHeld = 1'b0;
            n.wHeld  = 1'b0;
            n.bValid = 1'b1;
            n.bResp  = wrResp;
            if (s.wLane0) begin
                if (s.awAddr == `DSC_ADDR_REV_GAIN) begin
                    n.rxBoost = s.wData[`DSC_BIT_RX_BOOST]; // [R6]
                    n.txCut   = s.wData[`DSC_BIT_TX_CUT];   // [R7]
                end else if (s.awAddr == `DSC_ADDR_CHAIN_CTL) begin
                    n.chainCtl = s.wData;
                end else if (s.awAddr == `DSC_ADDR_INT_ENABLE) begin
                    n.intEn = s.wData[2:0];
                end
            end
        end

        // Sticky link error; a fault wins over a clearing write
        if (wrFire && s.wLane0 && s.awAddr == `DSC_ADDR_LINE_STATUS
            && !s.wData[`DSC_BIT_LINK_ERR]) begin
            n.linkErr = 1'b0;                               // [R1]
        end
        if (s.lineS2.fault) begin
            n.linkErr = 1'b1;                               // [R1]
        end

        n.intStat = (s.intStat & ~intClear) | intEvents;

        // Read channel
        if (s.rValid && s_axi_rready) begin
            n.rValid = 1'b0;
        end
        if (rdFire) begin
            n.rValid = 1'b1;
            n.rData  = rdVal;
            n.rResp  = rdResp;
        end

        // Frame sync spacing counted in serial clock periods
        if (sclkRise) begin
            n.framePulse = 1'b0;
            if (s.frameCnt >= framePeriod - 6'h01) begin    // [R12]
                n.frameCnt   = 6'h00;
                n.framePulse = chainOn;                     // [R15]
            end else begin
                n.frameCnt = s.frameCnt + 6'h01;
            end
        end
        if (!chainOn) begin
            n.framePulse = 1'b0;
        end

        // Ring detect only when chained; otherwise a control level
        if (chainOn) begin                                  // [R15]
            n.ringPin = chainCfg.ringPolarity ? s.lineS2.ring
                                              : !s.lineS2.ring; // [R14]
        end else begin
            n.ringPin = controlIn;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk_sys or negedge rstSyncB) begin
        if (!rstSyncB) begin
            s          <= '0;
            s.chainCtl <= `DSC_CHAIN_RST_M01;
            s.bResp    <= `DSC_RESP_OKAY;
            s.rResp    <= `DSC_RESP_OKAY;
        end else begin
            s <= n;
        end
    end

endmodule

// file: testbench/dsc_reg_bank_checker.sv
// Purpose: Port checks of the register bank
// Assumes: One clk_sys domain, rst_b active low
// Notes:   Bound to every dsc_reg_bank
`timescale 1ns/1ns
module dsc_reg_bank_checker
    import dsc_pkg::*;
(
    input wire logic              clk_sys,          // Clock
    input wire logic              rst_b,            // Reset
    input wire logic              s_axi_arvalid,    // Read addr valid
    input wire logic              s_axi_arready,    // Read addr ready
    input wire logic [31:0]       s_axi_rdata,      // Read data
    input wire logic              s_axi_rvalid,     // Read valid
    input wire logic              s_axi_rready,     // Read ready
    input wire dsc_line_in_type   lineIn,           // Line pins
    input wire logic              controlIn,        // Control level
    input wire logic              ringOrControlPin, // Ring pin
    input wire logic              delayedSyncPin,   // Sync pin
    input wire logic              rxBoost,          // Boost
    input wire logic              s_axi_bvalid,     // Write resp valid
    input wire dsc_chain_cfg_type chainCfg          // Chain setup
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // ****************
    // Sequences
    // ****************
    // Ring crosses two flops and a register
    sequence s_ring_steady;
        ($stable(lineIn.ring) && $stable(chainCfg) && chainCfg.enable) [*5];
    endsequence
    sequence s_ctl_steady;
        ($stable(controlIn) && !chainCfg.enable) [*3];
    endsequence
    // ****************
    // Assertions
    // ****************
    chk_cfg_gated: assert property (!chainCfg.enable |-> chainCfg == '0)
        else $error("chain setup not gated");
    chk_ring_level: assert property (s_ring_steady |->
        ringOrControlPin == (lineIn.ring == chainCfg.ringPolarity))
        else $error("ring pin level wrong");
    chk_ctl_follow: assert property (s_ctl_steady |-> ringOrControlPin == controlIn)
        else $error("control level not passed");
    chk_sync_quiet: assert property ((!chainCfg.enable) [*4] |-> !delayedSyncPin)
        else $error("sync pin active unchained");
    chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
        else $error("upper read bits set");
    chk_boost_write: assert property ($changed(rxBoost) |-> $rose(s_axi_bvalid))
        else $error("boost changed without write");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule

bind dsc_reg_bank dsc_reg_bank_checker u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lineIn(lineIn),
    .controlIn(controlIn), .ringOrControlPin(ringOrControlPin),
    .delayedSyncPin(delayedSyncPin), .rxBoost(rxBoost),
    .s_axi_bvalid(s_axi_bvalid), .chainCfg(chainCfg)
);

// file: testbench/dsc_host_model.sv
// Purpose: Host processor on the shared serial bus
// Assumes: Serial clock 125 ns, low while idle
// Notes:   Counts serial clocks between delayed syncs
`timescale 1ns/1ns
module dsc_host_model (
    input  wire logic       run,      // Clock the bus
    input  wire logic       syncPin,  // Delayed frame sync
    output logic            sclk,     // Serial clock
    output logic [6:0]      gap       // Clocks per frame
);
    logic [6:0] cnt = '0;
    logic       syncPrev = 1'h0;
    initial begin
        sclk = 1'h0;
        #1;
        forever begin
            #62 sclk = run;
            #63 sclk = 1'h0;
        end
    end
    always @(posedge sclk) begin
        syncPrev <= syncPin;
        cnt <= (syncPin && !syncPrev) ? 7'h01 : cnt + 7'h01;
        if (syncPin && !syncPrev) gap <= cnt;
    end
endmodule

// file: testbench/test_daa_status_and_chain_regs.sv
// Purpose: Self-checking bench of the register bank
// Assumes: AXI4-Lite master, host model on serial bus
// Notes:   Ends through test_done only
`timescale 1ns/1ns
module test_daa_status_and_chain_regs
    import dsc_pkg::*;
;
    logic clk_sys, rst_b, awV, wV, bRdy, arV, rRdy, ctl, run;
    logic awR, wR, bV, arR, rV, pin, sync, boost, cut, irq, sclk;
    logic [7:0] awA, arA;
    logic [31:0] wD, rD;
    logic [1:0] bResp, rResp, mode;
    logic [6:0] gap;
    dsc_line_in_type line;
    dsc_chain_cfg_type cfg;
    int failures = 0;
    int comparisons = 0;
    dsc_reg_bank dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awA),
        .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR),
        .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
        .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
        .s_axi_rready(rRdy), .lineIn(line), .serialClkPin(sclk),
        .serialModePin(mode), .controlIn(ctl), .ringOrControlPin(pin),
        .delayedSyncPin(sync), .rxBoost(boost), .txCut(cut), .chainCfg(cfg),
        .irq(irq));
    dsc_host_model host (.run(run), .syncPin(sync), .sclk(sclk), .gap(gap));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        awA <= a;
        wD <= {24'h00_0000, d};
        awV <= 1'h1;
        wV <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (awR) awV <= 1'h0;
            if (wR) wV <= 1'h0;
            bRdy <= !awV && !wV;
        end while (!(bV && bRdy));
        bRdy <= 1'h0;
        chk("bresp", er, bResp);
    endtask
    // Ready raised late so held read data is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk_sys);
        arA <= a;
        arV <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (arR) arV <= 1'h0;
            rRdy <= !arV;
        end while (!(rV && rRdy));
        rRdy <= 1'h0;
        chk("rdata", e, rD);
        chk("rresp", er, rResp);
    endtask
    task automatic t_reset;
        rd(8'h38, 32'h0000_0002, 2'h0);
        rd(8'h34, 32'h0000_0068, 2'h0);
        wr(8'h30, 8'h7f, 2'h0);
        wr(8'h34, 8'hbc, 2'h0);
        rd(8'h30, 32'h0000_004f, 2'h0);
        rd(8'h34, 32'h0000_0068, 2'h0);
        line.lock <= 1'h0;
        tick(4);
        rd(8'h30, 32'h0000_000f, 2'h0);
        $display("t_reset done");
    endtask
    task automatic t_link;
        line.lock <= 1'h1;
        line.fault <= 1'h1;
        tick(4);
        line.fault <= 1'h0;
        tick(4);
        chk("irq", 1'h0, irq);
        rd(8'h40, 32'h0000_0003, 2'h0);
        wr(8'h48, 8'h01, 2'h0);
        chk("irq", 1'h1, irq);
        wr(8'h44, 8'h03, 2'h0);
        chk("irq", 1'h0, irq);
        rd(8'h30, 32'h0000_00cf, 2'h0);
        wr(8'h30, 8'h00, 2'h0);
        rd(8'h30, 32'h0000_004f, 2'h0);
        $display("t_link done");
    endtask
    task automatic t_gain;
        wr(8'h34, 8'hff, 2'h0);
        chk("boost", 1'h1, boost);
        chk("cut", 1'h1, cut);
        rd(8'h34, 32'h0000_006b, 2'h0);
        wr(8'h34, 8'h02, 2'h0);
        chk("cut", 1'h0, cut);
        wr(8'h34, 8'h00, 2'h0);
        chk("boost", 1'h0, boost);
        $display("t_gain done");
    endtask
    task automatic t_chain;
        logic [1:0] fm;
        wr(8'h38, 8'hfe, 2'h0);
        chk("cfg", 8'h00, cfg);
        ctl <= 1'h1;
        tick(4);
        chk("pin", 1'h1, pin);
        for (int i = 0; i < 8; i++) begin
            fm = (i % 3 == 0) ? 2'h0 : 2'(i % 3 + 1);
            wr(8'h38, {i[2:0], fm, 3'h7}, 2'h0);
            chk("cfg", {1'h1, i[2:0], fm, 2'h3}, cfg);
            rd(8'h38, {24'h00_0000, i[2:0], 5'h07}, 2'h0);
        end
        line.ring <= 1'h1;
        tick(6);
        chk("pin", 1'h1, pin);
        wr(8'h38, 8'hb5, 2'h0);
        tick(4);
        chk("pin", 1'h0, pin);
        run <= 1'h1;
        tick(1600);
        chk("gap", 7'h10, gap);
        wr(8'h38, 8'h21, 2'h0);
        tick(3200);
        chk("gap", 7'h20, gap);
        run <= 1'h0;
        ctl <= 1'h0;
        wr(8'h38, 8'h20, 2'h0);
        $display("t_chain done");
    endtask
    task automatic t_bus;
        rd(8'h3c, 32'h0000_0000, 2'h2);
        wr(8'h20, 8'h55, 2'h2);
        mode <= 2'h2;
        rst_b <= 1'h0;
        tick(6);
        rst_b <= 1'h1;
        tick(6);
        // Word format bits of the mode 2 reset value are write-only
        rd(8'h38, 32'h0000_0027, 2'h0);
        $display("t_bus done");
    endtask
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        {awV, wV, bRdy, arV, rRdy, ctl, run, rst_b} = '0;
        {awA, arA, wD, mode} = '0;
        line = '{lock: 1'h1, loopLevel: 4'hf, intlSupport: 1'h1, revision: 4'ha, default: 0};
        tick(6);
        rst_b <= 1'h1;
        tick(6);
        t_reset;
        t_link;
        t_gain;
        t_chain;
        t_bus;
        test_done;
    end
    // Tests need about 5000 cycles
    initial begin
        #200000;
        failures++;
        test_done;
    end
endmodule
